// File: design/pts_sched.sv
// Process-data-object transmission scheduler with AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "pts_consts.svh"

module pts_sched
   import pts_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic can_rx_valid,
   input wire logic [10:0] can_rx_id,
   input wire logic can_rx_rtr,
   input wire logic [3:0] can_rx_dlc,
   input wire logic [63:0] can_rx_data,
   output logic can_tx_valid,
   input wire logic can_tx_ready,
   output logic [10:0] can_tx_id,
   output logic [3:0] can_tx_dlc,
   output logic [63:0] can_tx_data,
   input wire logic [63:0] app_in,
   input wire logic app_event,
   output logic app_rtr_req,
   input wire logic app_fresh,
   output logic [63:0] app_out,
   output logic app_rx_timeout,
   output logic rx_err,
   output logic sync_err
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   function automatic logic type_rsvd(input logic [7:0] t);
      type_rsvd = (t >= `PTS_TYPE_RSV_LO) && (t <= `PTS_TYPE_RSV_HI);
   endfunction

   function automatic logic type_sync(input logic [7:0] t);
      type_sync = (t <= `PTS_TYPE_CYC_MAX);
   endfunction

   // Bytes beyond the mapping count are sent and applied as zero
   function automatic logic [63:0] map_mask(input logic [3:0] n);
      logic [63:0] m;
      m = 64'h0;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n) begin
            m[i*8 +: 8] = 8'hff;
         end
      end
      map_mask = m;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   logic [31:0] tx_cobid, rx_cobid, sync_period;
   logic [7:0] tx_type, rx_type;
   logic [15:0] tx_inhibit, tx_evtimer, rx_evtimer;
   logic [3:0] tx_mapcnt, rx_mapcnt;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_got, w_got;
   pts_state_t state;
   logic tx_queued, evt_pend;
   logic [63:0] rx_buf;

   wire wr_go = aw_got && w_got && !s_axi_bvalid;
   wire [31:0] wval = merge(32'h0, w_data, w_strb);
   wire wr_type_bad = type_rsvd(wval[7:0]);
   wire wr_map_bad = wval[3:0] > `PTS_MAX_BYTES;
   wire wr_known = (aw_addr <= `PTS_A_CTRL) && (aw_addr[1:0] == 2'b00);
   wire wr_bad = !wr_known
      || (((aw_addr == `PTS_A_TX_TYPE) || (aw_addr == `PTS_A_RX_TYPE))
         && wr_type_bad)
      || (((aw_addr == `PTS_A_TX_MAPCNT) || (aw_addr == `PTS_A_RX_MAPCNT))
         && wr_map_bad);
   wire wr_ok = wr_go && !wr_bad;
   wire clr_err = wr_ok && (aw_addr == `PTS_A_CTRL) && wval[`PTS_CTRL_CLR];

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PTS_RESP_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_got <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_got <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_bad ? `PTS_RESP_SLVERR : `PTS_RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Whole-register writes; strobes merge into the old value only for the COB-IDs and SYNC period, others take unstrobed bytes as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_cobid <= `PTS_RST_TX_COBID;
         rx_cobid <= `PTS_RST_RX_COBID;
         tx_type <= `PTS_RST_TYPE;
         rx_type <= `PTS_RST_TYPE;
         tx_inhibit <= 16'h0;
         tx_evtimer <= 16'h0;
         rx_evtimer <= 16'h0;
         tx_mapcnt <= `PTS_RST_MAPCNT;
         rx_mapcnt <= `PTS_RST_MAPCNT;
         sync_period <= 32'h0;
      end else if (wr_ok) begin
         case (aw_addr)
            `PTS_A_TX_COBID: tx_cobid <= merge(tx_cobid, w_data, w_strb);
            `PTS_A_RX_COBID: rx_cobid <= merge(rx_cobid, w_data, w_strb);
            `PTS_A_TX_TYPE: tx_type <= wval[7:0];
            `PTS_A_RX_TYPE: rx_type <= wval[7:0];
            `PTS_A_TX_INHIBIT: tx_inhibit <= wval[15:0];
            `PTS_A_TX_EVTIMER: tx_evtimer <= wval[15:0];
            `PTS_A_RX_EVTIMER: rx_evtimer <= wval[15:0];
            `PTS_A_TX_MAPCNT: tx_mapcnt <= wval[3:0];
            `PTS_A_RX_MAPCNT: rx_mapcnt <= wval[3:0];
            `PTS_A_SYNC_PERIOD: sync_period <= merge(sync_period, w_data,
               w_strb);
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   wire [31:0] status = {26'h0, (state == PTS_RTRW), tx_queued, evt_pend,
      |rx_buf, sync_err, rx_err};
   logic [31:0] rd_mux;
   always_comb begin
      case (s_axi_araddr)
         `PTS_A_TX_COBID: rd_mux = tx_cobid;
         `PTS_A_RX_COBID: rd_mux = rx_cobid;
         `PTS_A_TX_TYPE: rd_mux = {24'h0, tx_type};
         `PTS_A_RX_TYPE: rd_mux = {24'h0, rx_type};
         `PTS_A_TX_INHIBIT: rd_mux = {16'h0, tx_inhibit};
         `PTS_A_TX_EVTIMER: rd_mux = {16'h0, tx_evtimer};
         `PTS_A_RX_EVTIMER: rd_mux = {16'h0, rx_evtimer};
         `PTS_A_TX_MAPCNT: rd_mux = {28'h0, tx_mapcnt};
         `PTS_A_RX_MAPCNT: rd_mux = {28'h0, rx_mapcnt};
         `PTS_A_SYNC_PERIOD: rd_mux = sync_period;
         `PTS_A_STATUS: rd_mux = status;
         default: rd_mux = 32'h0;
      endcase
   end
   wire rd_known = (s_axi_araddr <= `PTS_A_CTRL)
      && (s_axi_araddr[1:0] == 2'b00);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `PTS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_known ? `PTS_RESP_OKAY : `PTS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ****************************************************************
   // Microsecond tick and frame decode
   // ****************************************************************
   logic [5:0] tick_cnt;
   wire tick = (tick_cnt == 6'(`PTS_TICK_CYC - 1));
   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_cnt <= 6'h0;
      end else begin
         tick_cnt <= tick_cnt + 6'h1;
      end
   end

   wire sync_hit = can_rx_valid && !can_rx_rtr
      && (can_rx_id == `PTS_SYNC_ID) && (can_rx_dlc == 4'h0);
   // Only the own receive identifier is taken; peers' transmit ids are not
   wire rx_hit = can_rx_valid && !can_rx_rtr
      && !rx_cobid[`PTS_COBID_OFF]
      && (can_rx_id == rx_cobid[`PTS_ID_MSB:0]);
   wire rtr_hit = can_rx_valid && can_rx_rtr
      && !tx_cobid[`PTS_COBID_OFF]
      && (can_rx_id == tx_cobid[`PTS_ID_MSB:0]);
   wire tx_off = tx_cobid[`PTS_COBID_OFF];

   // ****************************************************************
   // Transmit triggers
   // ****************************************************************
   logic [63:0] app_prev, tx_snap;
   logic [7:0] sync_n;
   logic [15:0] inh_cnt, tx_et;
   logic [5:0] inh_pre;
   wire inh_tick = (inh_pre == 6'(`PTS_TICK_CYC - 1));
   wire in_change = (app_in != app_prev);
   wire t_acyc = (tx_type == `PTS_TYPE_ACYC);
   wire t_cyc = !t_acyc && type_sync(tx_type);
   wire t_async = (tx_type == `PTS_TYPE_MFR) || (tx_type == `PTS_TYPE_PROF);
   wire app_evt = (tx_type == `PTS_TYPE_MFR) ? app_event
      : in_change;
   wire et_exp = t_async && (tx_evtimer != 16'h0)
      && (tx_et >= tx_evtimer);
   wire cyc_due = t_cyc && sync_hit
      && ((sync_n + 8'h1) >= tx_type);
   wire acyc_due = t_acyc && sync_hit && (evt_pend || in_change);
   wire rtr_sync = rtr_hit && (tx_type == `PTS_TYPE_RTR_SYNC);
   wire rtr_async = rtr_hit && (tx_type == `PTS_TYPE_RTR_ASYNC);
   wire fresh_ok = (state == PTS_RTRW) && app_fresh;
   wire trig = !tx_off && (cyc_due || acyc_due || rtr_sync || fresh_ok
      || (t_async && (app_evt || et_exp)));
   wire load = tx_queued && (state == PTS_IDLE) && (inh_cnt == 16'h0)
      && !tx_off;
   wire tx_fire = can_tx_valid && can_tx_ready;
   wire snap_on_sync = type_sync(tx_type)
      || (tx_type == `PTS_TYPE_RTR_SYNC);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         app_prev <= 64'h0;
         tx_snap <= 64'h0;
         evt_pend <= 1'b0;
         tx_queued <= 1'b0;
         sync_n <= 8'h0;
      end else begin
         app_prev <= app_in;
         if (snap_on_sync ? sync_hit : 1'b1) begin
            tx_snap <= app_in;
         end
         if (t_acyc && in_change && !sync_hit) begin
            evt_pend <= 1'b1;
         end else if (sync_hit || !t_acyc) begin
            evt_pend <= 1'b0;
         end
         if (sync_hit && t_cyc) begin
            sync_n <= cyc_due ? 8'h0 : sync_n + 8'h1;
         end
         if (trig) begin
            tx_queued <= 1'b1;
         end else if (load || tx_off) begin
            tx_queued <= 1'b0;
         end
      end
   end

   // Inhibit and event timers, both in microsecond ticks; inhibit has
   // its own prescaler restarted at each send, so a partial first tick
   // can never shorten the gap between two frames
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         inh_cnt <= 16'h0;
         inh_pre <= 6'h0;
         tx_et <= 16'h0;
      end else begin
         if (tx_fire || inh_tick) begin
            inh_pre <= 6'h0;
         end else begin
            inh_pre <= inh_pre + 6'h1;
         end
         if (tx_fire) begin
            inh_cnt <= tx_inhibit;
         end else if (inh_tick && inh_cnt != 16'h0) begin
            inh_cnt <= inh_cnt - 16'h1;
         end
         if (load || (t_async && app_evt) || et_exp) begin
            tx_et <= 16'h0;
         end else if (tick) begin
            tx_et <= tx_et + 16'h1;
         end
      end
   end

   // ****************************************************************
   // Transmit sequencer
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= PTS_IDLE;
         can_tx_valid <= 1'b0;
         can_tx_id <= 11'h0;
         can_tx_dlc <= 4'h0;
         can_tx_data <= 64'h0;
         app_rtr_req <= 1'b0;
      end else begin
         app_rtr_req <= 1'b0;
         case (state)
            PTS_IDLE: begin
               if (rtr_async && !tx_queued) begin
                  app_rtr_req <= 1'b1;
                  state <= PTS_RTRW;
               end else if (load) begin
                  // Bytes leave in physical input order, byte 0 first
                  can_tx_data <= (snap_on_sync ? tx_snap : app_in)
                     & map_mask(tx_mapcnt);
                  can_tx_dlc <= tx_mapcnt;
                  can_tx_id <= tx_cobid[`PTS_ID_MSB:0];
                  can_tx_valid <= 1'b1;
                  state <= PTS_SEND;
               end
            end
            PTS_RTRW: begin
               if (app_fresh || tx_off) begin
                  state <= PTS_IDLE;
               end
            end
            PTS_SEND: begin
               if (can_tx_ready) begin
                  can_tx_valid <= 1'b0;
                  state <= PTS_IDLE;
               end
            end
            default: state <= PTS_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Receive path and watchdogs
   // ****************************************************************
   logic rx_full;
   logic [15:0] rx_wd;
   logic [31:0] sync_cnt;
   wire r_sync = type_sync(rx_type);
   wire rx_exp = (rx_evtimer != 16'h0) && (rx_wd >= rx_evtimer);
   wire sync_lost = (sync_period != 32'h0) && (sync_cnt > sync_period);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_buf <= 64'h0;
         rx_full <= 1'b0;
         app_out <= `PTS_FAULT_VAL;
      end else begin
         if (rx_hit) begin
            rx_buf <= can_rx_data & map_mask(rx_mapcnt);
         end
         if (rx_hit && r_sync) begin
            rx_full <= 1'b1;
         end else if (sync_hit) begin
            rx_full <= 1'b0;
         end
         // Fault state wins while SYNC is missing
         if (sync_err) begin
            app_out <= `PTS_FAULT_VAL;
         end else if (sync_hit && rx_full) begin
            app_out <= rx_buf;
         end else if (rx_hit && !r_sync) begin
            app_out <= can_rx_data & map_mask(rx_mapcnt);
         end
      end
   end

   // Error flags: a new fault in the clearing cycle still sets the flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_wd <= 16'h0;
         sync_cnt <= 32'h0;
         rx_err <= 1'b0;
         sync_err <= 1'b0;
         app_rx_timeout <= 1'b0;
      end else begin
         app_rx_timeout <= rx_exp;
         if (rx_hit || rx_exp) begin
            rx_wd <= 16'h0;
         end else if (tick) begin
            rx_wd <= rx_wd + 16'h1;
         end
         if (sync_hit) begin
            sync_cnt <= 32'h0;
         end else if (tick && !sync_lost) begin
            sync_cnt <= sync_cnt + 32'h1;
         end
         rx_err <= rx_exp || (rx_err && !clr_err);
         sync_err <= sync_lost || (sync_err && !clr_err);
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence rtr_in;
      state == PTS_IDLE && rtr_async && !tx_queued;
   endsequence
   sequence rtr_out;
      app_rtr_req ##1 !app_rtr_req;
   endsequence

   rsvd_type_kept_a: assert property (
      wr_go && aw_addr == `PTS_A_TX_TYPE && wr_type_bad
      |=> $stable(tx_type) && s_axi_bresp == `PTS_RESP_SLVERR)
      else $error("reserved type was stored");
   sync_apply_a: assert property (
      sync_hit && rx_full && !sync_err |=> app_out == $past(rx_buf))
      else $error("buffered data not applied on sync");
   inhibit_load_a: assert property (
      tx_fire |=> inh_cnt == $past(tx_inhibit)
         && (inh_cnt == 16'h0 || !load))
      else $error("inhibit not started after send");
   off_silent_a: assert property (
      tx_off && !can_tx_valid |=> !can_tx_valid)
      else $error("disabled object transmitted");
   rtr_handoff_a: assert property (
      rtr_in |=> rtr_out and state == PTS_RTRW)
      else $error("remote request not passed on");
   frame_len_a: assert property (
      can_tx_valid |-> can_tx_dlc <= `PTS_MAX_BYTES)
      else $error("frame longer than eight bytes");
   sync_loss_a: assert property (
      sync_lost |=> sync_err ##1 app_out == `PTS_FAULT_VAL)
      else $error("sync loss not flagged");
   cyclic_due_a: assert property (
      cyc_due && !tx_off |=> tx_queued && sync_n == 8'h0)
      else $error("nth sync did not queue");
   rx_filter_a: assert property (
      can_rx_valid && !rx_hit |=> $stable(rx_buf))
      else $error("foreign frame accepted");

endmodule

// File: design/pts_consts.svh
// Offsets, field positions, reset values and timing counts of the scheduler
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PTS_A_TX_COBID 8'h00
`define PTS_A_TX_TYPE 8'h04
`define PTS_A_TX_INHIBIT 8'h08
`define PTS_A_TX_EVTIMER 8'h0c
`define PTS_A_TX_MAPCNT 8'h10
`define PTS_A_RX_COBID 8'h14
`define PTS_A_RX_TYPE 8'h18
`define PTS_A_RX_EVTIMER 8'h1c
`define PTS_A_RX_MAPCNT 8'h20
`define PTS_A_SYNC_PERIOD 8'h24
`define PTS_A_STATUS 8'h28
`define PTS_A_CTRL 8'h2c

// ****************************************************************
// Fields and values
// ****************************************************************
`define PTS_COBID_OFF 31
`define PTS_ID_MSB 10
`define PTS_SYNC_ID 11'h080
`define PTS_TYPE_ACYC 8'h00
`define PTS_TYPE_CYC_MAX 8'hf0
`define PTS_TYPE_RSV_LO 8'hf1
`define PTS_TYPE_RSV_HI 8'hfb
`define PTS_TYPE_RTR_SYNC 8'hfc
`define PTS_TYPE_RTR_ASYNC 8'hfd
`define PTS_TYPE_MFR 8'hfe
`define PTS_TYPE_PROF 8'hff
`define PTS_MAX_BYTES 4'h8
`define PTS_RST_TYPE 8'hff
`define PTS_RST_MAPCNT 4'h8
`define PTS_RST_TX_COBID 32'h0000_0181
`define PTS_RST_RX_COBID 32'h0000_0201
`define PTS_FAULT_VAL 64'h0000_0000_0000_0000
`define PTS_CTRL_CLR 0
`define PTS_RESP_OKAY 2'b00
`define PTS_RESP_SLVERR 2'b10

// ****************************************************************
// Timing: all timer registers count in microsecond ticks
// ****************************************************************
`define PTS_CLK_MHZ 50
`define PTS_TICK_US 1
`define PTS_TICK_CYC (`PTS_TICK_US * `PTS_CLK_MHZ)

`endif

// File: design/pts_pkg.sv
// Types shared by the transmission scheduler
package pts_pkg;

   typedef enum logic [2:0] {
      PTS_IDLE = 3'b001,
      PTS_RTRW = 3'b010,
      PTS_SEND = 3'b100
   } pts_state_t;

endpackage

// File: testbench/pts_can_peer.sv
// Behavioural CAN peer: frame source, SYNC producer and transmit sink
`timescale 1ns/10ps
module pts_can_peer (
   input wire logic aclk,
   input wire logic slow,
   output logic can_rx_valid,
   output logic [10:0] can_rx_id,
   output logic can_rx_rtr,
   output logic [3:0] can_rx_dlc,
   output logic [63:0] can_rx_data,
   input wire logic can_tx_valid,
   output logic can_tx_ready,
   input wire logic [10:0] can_tx_id,
   input wire logic [3:0] can_tx_dlc,
   input wire logic [63:0] can_tx_data
);
   int cyc = 0;
   int tx_cnt = 0;
   int tx_time = 0;
   logic [10:0] tx_id;
   logic [3:0] tx_dlc;
   logic [63:0] tx_data;
   initial begin
      can_rx_valid = 1'b0;
      can_rx_id = 11'h7ff;
      can_rx_rtr = 1'b0;
      can_rx_dlc = 4'h0;
      can_rx_data = 64'h0;
      can_tx_ready = 1'b0;
   end
   // A slow controller accepts only every other pair of cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      can_tx_ready <= slow ? cyc[1] : 1'b1;
      if (can_tx_valid && can_tx_ready) begin
         tx_cnt <= tx_cnt + 1;
         tx_time <= cyc;
         tx_id <= can_tx_id;
         tx_dlc <= can_tx_dlc;
         tx_data <= can_tx_data;
      end
   end
   task send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
             input logic [63:0] d);
      @(posedge aclk);
      can_rx_valid <= 1'b1;
      can_rx_id <= id;
      can_rx_rtr <= rtr;
      can_rx_dlc <= dlc;
      can_rx_data <= d;
      @(posedge aclk);
      can_rx_valid <= 1'b0;
      // Released id and data lines show no stale value; rtr and dlc keep theirs
      can_rx_id <= ~id;
      can_rx_data <= ~d;
   endtask
   task sync;
      send(11'h080, 1'b0, 4'h0, 64'h0);
   endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench of the transmission scheduler
`timescale 1ns/10ps
`include "pts_consts.svh"
module testbench;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0;
   logic rready = 0, app_fresh = 0, slow = 0, app_ev = 0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, seed = 32'h3854, v;
   logic [63:0] app_in = 64'h0;
   wire awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready;
   wire rx_valid, rx_rtr, rtr_req, rx_tmo, rx_err, sync_err;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [10:0] rx_id, tx_id;
   wire [3:0] rx_dlc, tx_dlc;
   wire [63:0] rx_data, tx_data, app_out;
   int miscompares = 0, num_checks = 0, t0, base, n;
   pts_sched DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .can_rx_valid(rx_valid), .can_rx_id(rx_id),
      .can_rx_rtr(rx_rtr), .can_rx_dlc(rx_dlc), .can_rx_data(rx_data),
      .can_tx_valid(tx_valid), .can_tx_ready(tx_ready), .can_tx_id(tx_id),
      .can_tx_dlc(tx_dlc), .can_tx_data(tx_data), .app_in(app_in),
      .app_event(app_ev), .app_rtr_req(rtr_req), .app_fresh(app_fresh),
      .app_out(app_out), .app_rx_timeout(rx_tmo), .rx_err(rx_err),
      .sync_err(sync_err));
   pts_can_peer peer (.aclk(aclk), .slow(slow), .can_rx_valid(rx_valid),
      .can_rx_id(rx_id), .can_rx_rtr(rx_rtr), .can_rx_dlc(rx_dlc),
      .can_rx_data(rx_data), .can_tx_valid(tx_valid),
      .can_tx_ready(tx_ready), .can_tx_id(tx_id), .can_tx_dlc(tx_dlc),
      .can_tx_data(tx_data));
   always #10 aclk = ~aclk;
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string s, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awv <= 1;
      wv <= 1;
      bready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awv && awready) awv <= 0;
         if (wv && wready) wv <= 0;
         if (bvalid) break;
      end
      bready <= 0;
      chk("bresp", er, bresp);
      if (n == 50) begin
         miscompares++;
         test_done;
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arv <= 1;
      rready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arv && arready) arv <= 0;
         if (rvalid) break;
      end
      rready <= 0;
      chk("rresp", er, rresp);
      chk("rdata", e, rdata);
      if (n == 50) begin
         miscompares++;
         test_done;
      end
   endtask
   // Waits with no frame run their full bound; any frame, expected or not, ends them early
   task wtx(input int lim, input bit ex);
      base = peer.tx_cnt;
      for (n = 0; n < lim && peer.tx_cnt == base; n++) @(posedge aclk);
      chk("tx_sent", ex, peer.tx_cnt != base);
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(`PTS_A_TX_COBID, `PTS_RST_TX_COBID, 0);
      rd(`PTS_A_RX_COBID, `PTS_RST_RX_COBID, 0);
      rd(`PTS_A_TX_TYPE, 255, 0);
      rd(`PTS_A_TX_MAPCNT, 8, 0);
      rd(8'h30, 0, `PTS_RESP_SLVERR);
      wr(`PTS_A_TX_TYPE, 32'hf1 + xs() % 11, `PTS_RESP_SLVERR);
      rd(`PTS_A_TX_TYPE, 255, 0);
      wr(`PTS_A_TX_INHIBIT, 3, 0);
      app_in <= {xs(), xs()};
      wtx(6, 1);
      chk("tx_data", app_in, peer.tx_data);
      chk("tx_id", 11'h181, peer.tx_id);
      chk("tx_dlc", 8, peer.tx_dlc);
      t0 = peer.tx_time;
      slow <= 1;
      app_in <= ~app_in;
      wtx(400, 1);
      chk("gap_ok", 1, peer.tx_time - t0 >= 150);
      wr(`PTS_A_TX_TYPE, 2, 0);
      t0 = peer.tx_cnt;
      repeat (4) begin
         peer.sync();
         repeat (200) @(posedge aclk);
      end
      chk("sync_sends", t0 + 2, peer.tx_cnt);
      wr(`PTS_A_TX_TYPE, 252, 0);
      peer.sync();
      wtx(200, 0);
      peer.send(11'h181, 1, 0, 0);
      wtx(200, 1);
      wr(`PTS_A_TX_TYPE, 253, 0);
      peer.send(11'h181, 1, 0, 0);
      for (n = 0; n < 20 && rtr_req !== 1'b1; n++) @(posedge aclk);
      chk("rtr_req", 1, rtr_req);
      app_in <= {xs(), xs()};
      app_fresh <= 1;
      @(posedge aclk);
      app_fresh <= 0;
      wtx(200, 1);
      chk("tx_data", app_in, peer.tx_data);
      wr(`PTS_A_TX_COBID, 32'h8000_0181, 0);
      wr(`PTS_A_TX_TYPE, 255, 0);
      app_in <= ~app_in;
      wtx(200, 0);
      wr(`PTS_A_TX_TYPE, 0, 0);
      wr(`PTS_A_TX_COBID, `PTS_RST_TX_COBID, 0);
      app_in <= ~app_in;
      wtx(20, 0);
      peer.sync();
      wtx(200, 1);
      wr(`PTS_A_TX_TYPE, 254, 0);
      app_ev <= 1;
      @(posedge aclk);
      app_ev <= 0;
      wtx(200, 1);
      wr(`PTS_A_TX_EVTIMER, 2, 0);
      wtx(200, 1);
      wr(`PTS_A_RX_TYPE, 0, 0);
      v = xs();
      peer.send(11'h201, 0, 8, {v, v});
      peer.send(11'h182, 0, 8, {xs(), xs()});
      repeat (5) @(posedge aclk);
      chk("out_held", 0, app_out);
      peer.sync();
      repeat (3) @(posedge aclk);
      chk("out_applied", {v, v}, app_out);
      wr(`PTS_A_RX_EVTIMER, 2, 0);
      for (n = 0; n < 200 && rx_tmo !== 1'b1; n++) @(posedge aclk);
      chk("rx_tmo", 1, rx_tmo);
      chk("rx_err", 1, rx_err);
      wr(`PTS_A_SYNC_PERIOD, 2, 0);
      repeat (200) @(posedge aclk);
      chk("sync_err", 1, sync_err);
      chk("fault_out", 0, app_out);
      test_done;
   end
endmodule
